// file: inc/adcph_consts.svh
`ifndef ADCPH_CONSTS_SVH
`define ADCPH_CONSTS_SVH

`define ADCPH_CLK_PERIOD_NS 4
`define ADCPH_CONV_TIME_NS 2800
`define ADCPH_CONV_CYCLES ((`ADCPH_CONV_TIME_NS + `ADCPH_CLK_PERIOD_NS - 1) / `ADCPH_CLK_PERIOD_NS)
`define ADCPH_DATA_W 16
`define ADCPH_BYTE_W 8
`define ADCPH_CNT_W 16
`define ADCPH_PIN_CNT 3
`define ADCPH_PIN_CS 0
`define ADCPH_PIN_RDCONV 1
`define ADCPH_PIN_BYTE 2
`define ADCPH_PIN_RST 3'h3
`define ADCPH_RESULT_RST 16'h0000
`define ADCPH_CNT_RST 16'h0000

`endif

// file: inc/adcph_pkg.sv
package adcph_pkg;
    typedef enum logic {ADCPH_IDLE, ADCPH_CONV} adcph_state_t;
    typedef logic [15:0] adcph_word_t;
endpackage

// file: inc/adcph_pin_if.sv
`timescale 1ns/1ps
interface adcph_pin_if;
    logic csN;
    logic rdConvN;
    logic byteSel;
    modport src (output csN, output rdConvN, output byteSel);
    modport dst (input csN, input rdConvN, input byteSel);
endinterface

// file: rtl/adcph_pin_sync.sv
`timescale 1ns/1ps
`include "adcph_consts.svh"
module adcph_pin_sync import adcph_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic csPinN,
    input wire logic rdConvPinN,
    input wire logic byteSelPin,
    adcph_pin_if.src pins
);
    localparam logic [`ADCPH_PIN_CNT-1:0] PIN_RST = `ADCPH_PIN_RST;
    logic [`ADCPH_PIN_CNT-1:0] rawPins;
    logic [`ADCPH_PIN_CNT-1:0] level;
    assign rawPins = {byteSelPin, rdConvPinN, csPinN};

    // a level counts only once stages two and three agree, so a late edge never splits
    genvar i;
    generate
        for (i = 0; i < `ADCPH_PIN_CNT; i++) begin : g_pin
            logic [2:0] stage_ff;
            logic [2:0] nxt_stage;
            logic level_ff;
            logic nxt_level;
            always_comb begin
                nxt_stage = {stage_ff[1:0], rawPins[i]};
                nxt_level = (stage_ff[1] == stage_ff[2]) ? stage_ff[2] : level_ff;
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    stage_ff <= {3{PIN_RST[i]}};
                    level_ff <= PIN_RST[i];
                end else begin
                    stage_ff <= nxt_stage;
                    level_ff <= nxt_level;
                end
            end
            assign level[i] = level_ff;
        end
    endgenerate

    assign pins.csN = level[`ADCPH_PIN_CS];
    assign pins.rdConvN = level[`ADCPH_PIN_RDCONV];
    assign pins.byteSel = level[`ADCPH_PIN_BYTE];
endmodule

// file: rtl/adcph_host_port.sv
`timescale 1ns/1ps
`include "adcph_consts.svh"
// Function
// - busy goes low at start, stays low until result register updated
// - byte select low gives the word in order, high swaps so the upper result byte sits on the lower lanes
// - chip select and read/convert combined; select falling with convert low starts
// - data lanes undriven unless chip select low and read/convert high
// - bit 15 carries the result msb
// - convert falling with select low and not busy starts a conversion
// - convert rising with select low drives the stored result
// - result is two's complement
// - bit 0 carries the result lsb
module adcph_host_port import adcph_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic csPinN,
    input wire logic rdConvPinN,
    input wire logic byteSelPin,
    input wire logic [15:0] sampleIn,
    output logic busyN,
    output logic [15:0] dataOut,
    output logic [15:0] dataOe
);
    localparam logic [`ADCPH_CNT_W-1:0] CONV_LAST = `ADCPH_CNT_W'(`ADCPH_CONV_CYCLES - 1);
    localparam int CONV_LEN = `ADCPH_CONV_CYCLES;

    adcph_pin_if pins();

    adcph_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .csPinN(csPinN),
        .rdConvPinN(rdConvPinN),
        .byteSelPin(byteSelPin),
        .pins(pins.src)
    );

    adcph_state_t state_ff, nxt_state;
    logic [`ADCPH_CNT_W-1:0] cnt_ff, nxt_cnt;
    adcph_word_t sample_ff, nxt_sample;
    adcph_word_t result_ff, nxt_result;
    logic combLowPrev_ff, nxt_combLowPrev;
    logic busyN_ff, nxt_busyN;
    logic [15:0] dataOut_ff, nxt_dataOut;
    logic [15:0] dataOe_ff, nxt_dataOe;
    logic combLow;
    logic startEvt;
    logic readOn;
    logic [`ADCPH_CNT_W-1:0] lowCnt_ff, nxt_lowCnt;

    // either input may fall last; the combined level going low is what starts
    assign combLow = !pins.csN && !pins.rdConvN;
    assign startEvt = combLow && !combLowPrev_ff && state_ff == ADCPH_IDLE;
    assign readOn = !pins.csN && pins.rdConvN;

    // conversion engine
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sample = sample_ff;
        nxt_result = result_ff;
        nxt_combLowPrev = combLow;
        case (state_ff)
            ADCPH_IDLE: begin
                if (startEvt) begin
                    nxt_state = ADCPH_CONV;
                    nxt_cnt = `ADCPH_CNT_RST;
                    nxt_sample = sampleIn; // hold phase: sample frozen
                end
            end
            ADCPH_CONV: begin
                // new strobes here fall through untouched
                if (cnt_ff == CONV_LAST) begin
                    nxt_state = ADCPH_IDLE;
                    nxt_result = sample_ff;
                end else begin
                    nxt_cnt = cnt_ff + `ADCPH_CNT_W'(1);
                end
            end
            default: nxt_state = ADCPH_IDLE;
        endcase
        nxt_busyN = (nxt_state != ADCPH_CONV);
    end

    // output lanes; a read during conversion shows the previous result
    always_comb begin
        nxt_dataOe = readOn ? 16'hFFFF : 16'h0000;
        if (pins.byteSel) begin
            nxt_dataOut = {result_ff[7:0], result_ff[15:8]};
        end else begin
            nxt_dataOut = result_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ADCPH_IDLE;
            cnt_ff <= `ADCPH_CNT_RST;
            sample_ff <= `ADCPH_RESULT_RST;
            result_ff <= `ADCPH_RESULT_RST;
            combLowPrev_ff <= 1'b1;
            busyN_ff <= 1'b1;
            dataOut_ff <= `ADCPH_RESULT_RST;
            dataOe_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sample_ff <= nxt_sample;
            result_ff <= nxt_result;
            combLowPrev_ff <= nxt_combLowPrev;
            busyN_ff <= nxt_busyN;
            dataOut_ff <= nxt_dataOut;
            dataOe_ff <= nxt_dataOe;
        end
    end

    // shadows the busy low time so the length check needs no long delay
    always_comb begin
        nxt_lowCnt = busyN_ff ? `ADCPH_CNT_RST : lowCnt_ff + `ADCPH_CNT_W'(1);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowCnt_ff <= `ADCPH_CNT_RST;
        end else begin
            lowCnt_ff <= nxt_lowCnt;
        end
    end

    assign busyN = busyN_ff;
    assign dataOut = dataOut_ff;
    assign dataOe = dataOe_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_busy_fall: assert property (startEvt |=> !busyN)
        else $error("busy did not fall after start");

    a_busy_length: assert property ($rose(busyN) |-> lowCnt_ff == CONV_LEN)
        else $error("busy low time wrong");

    a_busy_hold: assert property ($fell(busyN) |-> !busyN [*8])
        else $error("busy released early");

    a_result_ready: assert property ($rose(busyN) |-> result_ff == sample_ff)
        else $error("result not updated when busy rose");

    a_start_ignored: assert property (!busyN && combLow && !combLowPrev_ff
                                      |=> $stable(sample_ff))
        else $error("start accepted while busy");

    a_lanes_off: assert property ((pins.csN || !pins.rdConvN) |=> dataOe == 16'h0000)
        else $error("data driven while deselected");

    a_lanes_on: assert property (readOn |=> dataOe == 16'hFFFF)
        else $error("data not driven on read");

    a_word_order: assert property (!pins.byteSel |=> dataOut == $past(result_ff))
        else $error("word lanes out of order");

    a_byte_swap: assert property (pins.byteSel |=> dataOut[15:8] == $past(result_ff[7:0]))
        else $error("low byte not on upper lane");

    a_byte_upper: assert property (
        pins.byteSel |=> dataOut[7:0] == $past(result_ff[15:8]))
        else $error("high byte not on lower lane");

    a_msb_lane: assert property (
        !pins.byteSel |=> dataOut[15] == $past(result_ff[15]))
        else $error("msb not on top lane");

    a_lsb_lane: assert property (
        !pins.byteSel |=> dataOut[0] == $past(result_ff[0]))
        else $error("lsb not on bottom lane");

    a_lanes_equal: assert property (
        dataOe == 16'h0000 || dataOe == 16'hFFFF)
        else $error("lane enables split");

    a_cs_off: assert property (
        pins.csN |=> dataOe == 16'h0000)
        else $error("data driven with select high");

    a_conv_off: assert property (
        !pins.rdConvN |=> dataOe == 16'h0000)
        else $error("data driven in convert mode");

    a_read_rise: assert property (
        !pins.csN && $rose(pins.rdConvN) |=> dataOe == 16'hFFFF)
        else $error("read edge did not enable lanes");

    a_cs_start: assert property (
        $fell(pins.csN) && !pins.rdConvN && busyN |=> !busyN)
        else $error("select edge did not start");

    a_rc_start: assert property (
        $fell(pins.rdConvN) && !pins.csN && busyN |=> !busyN)
        else $error("convert edge did not start");

    a_sample_taken: assert property (
        startEvt |=> sample_ff == $past(sampleIn))
        else $error("sample not frozen at start");

    a_sample_hold: assert property (
        state_ff == ADCPH_CONV |=> $stable(sample_ff))
        else $error("sample moved during conversion");

    a_result_hold: assert property (
        state_ff == ADCPH_CONV && cnt_ff != CONV_LAST |=> $stable(result_ff))
        else $error("result moved before conversion end");

    a_idle_high: assert property (
        state_ff == ADCPH_IDLE |-> busyN)
        else $error("busy low while idle");

    a_no_restart: assert property (
        $rose(busyN) && combLowPrev_ff |=> busyN)
        else $error("held level restarted a conversion");

    a_cnt_range: assert property (
        cnt_ff <= CONV_LAST)
        else $error("conversion counter overran");
endmodule

// file: verification/adcph_host_model.sv
`timescale 1ns/1ps
module adcph_host_model (
    input wire logic clk,
    output logic csPinN,
    output logic rdConvPinN,
    output logic byteSelPin,
    output logic [15:0] sampleIn
);
    initial begin
        csPinN = 1'b1;
        rdConvPinN = 1'b1;
        byteSelPin = 1'b0;
        sampleIn = 16'h0000;
    end
    // levels change just after an edge and then hold; a low combined level is made only to start
    task automatic setPins(input logic cs, input logic rc, input logic bs);
        @(posedge clk);
        csPinN <= cs;
        rdConvPinN <= rc;
        byteSelPin <= bs;
    endtask
    task automatic setSample(input logic [15:0] s);
        @(posedge clk);
        sampleIn <= s;
    endtask
endmodule

// file: verification/adc_parallel_host_interface_tb_top.sv
`timescale 1ns/1ps
`include "adcph_consts.svh"
module adc_parallel_host_interface_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic csPinN, rdConvPinN, byteSelPin, busyN;
    logic [15:0] sampleIn, dataOut, dataOe;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    adcph_host_model adcph_host_model_inst (.clk(clk), .csPinN(csPinN), .rdConvPinN(rdConvPinN),
        .byteSelPin(byteSelPin), .sampleIn(sampleIn));
    adcph_host_port adcph_host_port_inst (.clk(clk), .rst_n(rst_n), .csPinN(csPinN),
        .rdConvPinN(rdConvPinN), .byteSelPin(byteSelPin), .sampleIn(sampleIn),
        .busyN(busyN), .dataOut(dataOut), .dataOe(dataOe));
    task automatic summarize();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pins(input logic cs, input logic rc, input logic bs);
        adcph_host_model_inst.setPins(cs, rc, bs);
    endtask
    // pins pass three sync stages, so let them settle before looking
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask
    // stamps the cycle busy is first seen low; optional restart attempt while busy
    task automatic busyRun(input bit poke, output int len);
        int c0;
        len = 0;
        while (busyN !== 1'b0 && len < 20) begin
            @(posedge clk);
            #1;
            len++;
        end
        c0 = cyc;
        if (poke) begin
            pins(1'b0, 1'b1, 1'b0);
            settle();
            pins(1'b0, 1'b0, 1'b0);
            adcph_host_model_inst.setSample(16'h1234);
        end
        while (busyN === 1'b0 && cyc - c0 < 1000) begin
            @(posedge clk);
            #1;
        end
        len = cyc - c0;
    endtask
    task automatic convertAndRead();
        int len;
        adcph_host_model_inst.setSample(16'h8001);
        pins(1'b0, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b0);
        busyRun(1'b1, len);
        chk(16'(len), 16'(`ADCPH_CONV_CYCLES));
        settle();
        chk({15'h0000, busyN}, 16'h0001);
        pins(1'b0, 1'b1, 1'b0);
        settle();
        chk(dataOe, 16'hffff);
        chk(dataOut, 16'h8001);
        pins(1'b0, 1'b1, 1'b1);
        settle();
        chk(dataOut, 16'h0180);
        pins(1'b1, 1'b1, 1'b0);
        settle();
        chk(dataOe, 16'h0000);
        pins(1'b0, 1'b0, 1'b0);
        settle();
        chk(dataOe, 16'h0000);
        busyRun(1'b0, len);
    endtask
    task automatic selectStarts();
        int len;
        pins(1'b1, 1'b0, 1'b0);
        settle();
        chk({15'h0000, busyN}, 16'h0001);
        adcph_host_model_inst.setSample(16'h7fff);
        pins(1'b0, 1'b0, 1'b0);
        busyRun(1'b0, len);
        chk(16'(len), 16'(`ADCPH_CONV_CYCLES));
        pins(1'b0, 1'b1, 1'b0);
        settle();
        chk(dataOut, 16'h7fff);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        convertAndRead();
        selectStarts();
        summarize();
    end
endmodule
